// ### verilog/cspm_defines.svh
`ifndef CSPM_DEFINES_SVH
`define CSPM_DEFINES_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CSPM_OFF_CTRL 8'h00
`define CSPM_OFF_PMON 8'h04
`define CSPM_OFF_TIME 8'h08
`define CSPM_OFF_ISTAT 8'h0C
`define CSPM_OFF_IMASK 8'h10
`define CSPM_OFF_STAT 8'h14
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CSPM_CTRL_START 0
`define CSPM_CTRL_BUSY 1
`define CSPM_CTRL_EVT 2
`define CSPM_PM_MGMT 0
`define CSPM_PM_PORT 1
`define CSPM_PM_SPI 2
`define CSPM_PM_LIM_LSB 4
`define CSPM_TIM_DT_LSB 0
`define CSPM_TIM_DR_LSB 4
`define CSPM_TIM_IA_LSB 8
`define CSPM_TIM_RP_LSB 12
`define CSPM_TIM_LP_LSB 16
`define CSPM_IRQ_DONE 0
`define CSPM_IRQ_RETRY 1
// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define CSPM_PM_RST 32'h0000_0000
`define CSPM_PM_MASK 32'h0000_0037
`define CSPM_TIM_RST 32'h0000_0000
`define CSPM_TIM_MASK 32'h0007_3737
`define CSPM_IRQ_MASK 32'h0000_0003
// ----------------------------------------
// Timing and counts
// ----------------------------------------
`define CSPM_CLK_MHZ 200
`define CSPM_PRI_STEP_NS 40
`define CSPM_SEC_STEP_NS 80
`define CSPM_CHARGE_NS 500
`define CSPM_PRI_STEP_CYC ((`CSPM_PRI_STEP_NS * `CSPM_CLK_MHZ + 999) / 1000)
`define CSPM_SEC_STEP_CYC ((`CSPM_SEC_STEP_NS * `CSPM_CLK_MHZ + 999) / 1000)
`define CSPM_CHARGE_CYC ((`CSPM_CHARGE_NS * `CSPM_CLK_MHZ + 999) / 1000)
`define CSPM_RETRY_TWO 8'h02
`define CSPM_RETRY_FOUR 8'h04
`endif

// ### verilog/cspm_pkg.sv
package cspm_pkg;
  typedef enum logic [1:0] {cspm_lim_none, cspm_lim_two, cspm_lim_four, cspm_lim_rsvd} cspm_limit_t;
  typedef enum {cspm_idle, cspm_disch, cspm_charge} cspm_state_t;
  typedef enum {cspm_dis_idle, cspm_dis_primary, cspm_dis_secondary} cspm_dis_state_t;
  typedef enum logic [1:0] {cspm_resp_okay, cspm_resp_exokay, cspm_resp_slverr, cspm_resp_decerr} cspm_resp_t;
endpackage : cspm_pkg

// ### verilog/cspm_discharge.sv
`timescale 1ns/100ps
`include "cspm_defines.svh"
module cspm_discharge #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [2:0] primary_discharge_time,
  input wire logic [1:0] secondary_discharge_time,
  output logic low_sw,
  output logic high_sw,
  output logic done
);
  cspm_pkg::cspm_dis_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_done;
  logic [CNT_W-1:0] pri_len, sec_len;

  if (CNT_W < 7) begin : g_bad_cnt
    $error("cspm_discharge counter too narrow");
  end

  function automatic logic [CNT_W-1:0] stage_len(input logic [2:0] sel, input int step);
    stage_len = CNT_W'((int'(sel) + 1) * step);
  endfunction : stage_len

  // Each stage has its own timer length, so one setting never moves the other.
  assign pri_len = stage_len(primary_discharge_time, `CSPM_PRI_STEP_CYC); // [R13] [R14]
  assign sec_len = stage_len({1'b0, secondary_discharge_time}, `CSPM_SEC_STEP_CYC); // [R13] [R15] [R16]

  always_comb begin
    next_state = state;
    next_cnt = cnt + 1'b1;
    next_done = 1'b0;
    if (start) begin
      next_state = cspm_pkg::cspm_dis_primary; // [R11]
      next_cnt = '0;
    end else begin
      unique case (state)
        cspm_pkg::cspm_dis_idle: next_cnt = '0;
        cspm_pkg::cspm_dis_primary: if (cnt == pri_len - 1'b1) begin
          next_state = cspm_pkg::cspm_dis_secondary; // [R12]
          next_cnt = '0;
        end
        cspm_pkg::cspm_dis_secondary: if (cnt == sec_len - 1'b1) begin
          next_state = cspm_pkg::cspm_dis_idle;
          next_done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= cspm_pkg::cspm_dis_idle;
      cnt <= '0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      done <= next_done;
    end
  end

  assign low_sw = (state == cspm_pkg::cspm_dis_primary); // [R12]
  assign high_sw = (state == cspm_pkg::cspm_dis_secondary); // [R12]

  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sec_length_a: assert property (high_sw && cnt == sec_len - 1'b1 && !start |=> done && !high_sw) // [R16]
    else $error("secondary stage did not end at its set length");
  pri_length_a: assert property (low_sw && cnt == pri_len - 1'b1 && !start |=> high_sw) // [R14]
    else $error("primary stage did not hand over at its set length");
endmodule : cspm_discharge

// ### verilog/cspm_retry_gate.sv
`timescale 1ns/100ps
`include "cspm_defines.svh"
module cspm_retry_gate (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic conv_start,
  input wire logic active,
  input wire logic mgmt_bus_switch,
  input wire logic port_write_strobe,
  input wire logic serial_periph_switch,
  input wire logic mgmt_bus_monitor_enable,
  input wire logic port_write_monitor_enable,
  input wire logic serial_periph_monitor_enable,
  input wire cspm_pkg::cspm_limit_t retry_limit_select,
  output logic retry,
  output logic [7:0] retry_count
);
  logic hit, allowed;
  logic [7:0] next_count;

  assign hit = (mgmt_bus_monitor_enable && mgmt_bus_switch) // [R2]
             || (port_write_monitor_enable && port_write_strobe) // [R3]
             || (serial_periph_monitor_enable && serial_periph_switch);

  always_comb begin
    unique case (retry_limit_select)
      cspm_pkg::cspm_lim_none: allowed = 1'b1; // [R5]
      cspm_pkg::cspm_lim_two: allowed = retry_count < `CSPM_RETRY_TWO; // [R6]
      cspm_pkg::cspm_lim_four, cspm_pkg::cspm_lim_rsvd: allowed = retry_count < `CSPM_RETRY_FOUR; // [R6]
    endcase
  end

  assign retry = active && hit && allowed; // [R1]

  always_comb begin
    next_count = retry_count;
    if (conv_start) begin
      next_count = '0; // [R19]
    end else if (retry && retry_count != 8'hFF) begin
      next_count = retry_count + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      retry_count <= '0;
    end else begin
      retry_count <= next_count;
    end
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  count_clear_a: assert property (conv_start |=> retry_count == 8'h00) // [R19]
    else $error("retry count not cleared at conversion start");
  limit_two_a: assert property (retry_limit_select == cspm_pkg::cspm_lim_two && retry_count >= 8'h02 |-> !retry) // [R6]
    else $error("more than two retries in one conversion");
  no_limit_a: assert property (retry_limit_select == cspm_pkg::cspm_lim_none && active && hit |-> retry) // [R5]
    else $error("requested retry dropped with no limit set");
  mgmt_watch_a: assert property (active && mgmt_bus_monitor_enable && mgmt_bus_switch && allowed |-> retry) // [R2]
    else $error("management bus switching not monitored");
  port_watch_a: assert property (active && port_write_monitor_enable && port_write_strobe && allowed |-> retry) // [R3]
    else $error("port write not monitored");
endmodule : cspm_retry_gate

// ### verilog/cspm_top.sv
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "cspm_defines.svh"
// Function
// R1 - An enabled monitored output switching mid-conversion makes the converter redo that bit.
// R2 - Management bus monitor enable set to 1 watches that bus's outputs.
// R3 - Port write monitor enable set to 1 treats port writes as events.
// R4 - Serial peripheral monitor enable resets to 0.
// R5 - Retry limit at reset value performs every requested retry.
// R6 - A selected limit caps retries at two or four, then conversion completes.
// R7 - Event flag sets on any retry, holds until software clear or reset.
// R8 - Wake with monitoring on and slow clock starts a new conversion.
// R9 - Software must keep the system clock at 5.5 MHz or more.
// R10 - Software enables monitors only for heavily loaded outputs.
// R11 - Every bit conversion begins with a two-stage sensor discharge.
// R12 - First stage uses the low-resistance switch, then the high-resistance one.
// R13 - Primary and secondary stage lengths come from separate timers and fields.
// R14 - Primary field has eight settings, 111b longest.
// R15 - Secondary field is two bits, 11b longest.
// R16 - Higher secondary setting only lengthens the secondary wait.
// R17 - Plain trace sensors keep timing, current, ramp and filter at defaults.
// R18 - Current field: 001b lowest, 000b highest, eight settings.
// R19 - Per-conversion retry counter clears at each conversion start.
module cspm_top #(
  parameter int ADDR_W = 8,
  parameter int CONV_BITS = 16,
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mgmt_bus_switch,
  input wire logic port_write_strobe,
  input wire logic serial_periph_switch,
  input wire logic wake_event,
  input wire logic sysclk_below_wake_min,
  output logic discharge_low_sw,
  output logic discharge_high_sw,
  output logic charge_enable,
  output logic [2:0] charge_current_select,
  output logic [1:0] ramp_control,
  output logic [2:0] lowpass_corner_select,
  output logic conv_busy,
  output logic conv_done,
  output logic irq
);
  localparam int BIT_W = $clog2(CONV_BITS);
  localparam logic [CNT_W-1:0] CHG_LAST = CNT_W'(`CSPM_CHARGE_CYC - 1);
  localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(CONV_BITS - 1);

  if (CONV_BITS < 2 || ADDR_W < 8 || CNT_W < 8) begin : g_bad_param
    $error("cspm_top parameters out of range");
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = a == ADDR_W'(`CSPM_OFF_CTRL) || a == ADDR_W'(`CSPM_OFF_PMON)
           || a == ADDR_W'(`CSPM_OFF_TIME) || a == ADDR_W'(`CSPM_OFF_ISTAT)
           || a == ADDR_W'(`CSPM_OFF_IMASK) || a == ADDR_W'(`CSPM_OFF_STAT);
  endfunction : reg_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  logic aw_got, next_aw_got, w_got, next_w_got, next_bvalid;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic [1:0] next_bresp;
  logic wr_fire, rd_fire, next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [31:0] pm_reg, next_pm_reg, tim_reg, next_tim_reg;
  logic [1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
  logic evt_flag, next_evt_flag;
  logic start_wr, evt_clr, stat_rd;
  cspm_pkg::cspm_state_t state, next_state;
  logic [BIT_W-1:0] bit_idx, next_bit_idx;
  logic [CNT_W-1:0] chg_cnt, next_chg_cnt;
  logic next_done, dis_start, dis_done, conv_start, start_req, wake_start;
  logic retry;
  logic [7:0] retry_count;
  logic mgmt_en, port_en, spi_en;
  cspm_pkg::cspm_limit_t lim;

  // ----------------------------------------
  // Register bus write channel
  // ----------------------------------------
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  always_comb begin
    next_aw_got = aw_got;
    next_aw_addr = aw_addr;
    next_w_got = w_got;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_hit(aw_addr) ? cspm_pkg::cspm_resp_okay : cspm_pkg::cspm_resp_slverr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got <= 1'b0;
      aw_addr <= '0;
      w_got <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= '0;
    end else begin
      aw_got <= next_aw_got;
      aw_addr <= next_aw_addr;
      w_got <= next_w_got;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ----------------------------------------
  // Register bus read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign stat_rd = rd_fire && s_axi_araddr == ADDR_W'(`CSPM_OFF_ISTAT);

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = reg_hit(s_axi_araddr) ? cspm_pkg::cspm_resp_okay : cspm_pkg::cspm_resp_slverr;
      next_rdata = '0;
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_CTRL)) begin
        next_rdata[`CSPM_CTRL_BUSY] = conv_busy;
        next_rdata[`CSPM_CTRL_EVT] = evt_flag;
      end
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_PMON)) next_rdata = pm_reg;
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_TIME)) next_rdata = tim_reg;
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_ISTAT)) next_rdata[1:0] = irq_stat;
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_IMASK)) next_rdata[1:0] = irq_mask;
      if (s_axi_araddr == ADDR_W'(`CSPM_OFF_STAT)) next_rdata = {8'h00, 8'(bit_idx), 8'h00, retry_count};
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= '0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ----------------------------------------
  // Control registers and interrupt
  // ----------------------------------------
  assign start_wr = wr_fire && aw_addr == ADDR_W'(`CSPM_OFF_CTRL) && w_strb[0] && w_data[`CSPM_CTRL_START];
  assign evt_clr = wr_fire && aw_addr == ADDR_W'(`CSPM_OFF_CTRL) && w_strb[0] && w_data[`CSPM_CTRL_EVT];

  always_comb begin
    next_pm_reg = pm_reg;
    next_tim_reg = tim_reg;
    next_irq_mask = irq_mask;
    if (wr_fire && aw_addr == ADDR_W'(`CSPM_OFF_PMON)) next_pm_reg = merge(pm_reg, w_data, w_strb, `CSPM_PM_MASK);
    if (wr_fire && aw_addr == ADDR_W'(`CSPM_OFF_TIME)) next_tim_reg = merge(tim_reg, w_data, w_strb, `CSPM_TIM_MASK);
    if (wr_fire && aw_addr == ADDR_W'(`CSPM_OFF_IMASK)) next_irq_mask = w_data[1:0] & 2'(`CSPM_IRQ_MASK);
    // A retry in the same cycle as a clear keeps the flag set.
    next_evt_flag = retry || (evt_flag && !evt_clr); // [R7]
    next_irq_stat = stat_rd ? 2'b00 : irq_stat;
    next_irq_stat[`CSPM_IRQ_DONE] = next_irq_stat[`CSPM_IRQ_DONE] || next_done;
    next_irq_stat[`CSPM_IRQ_RETRY] = next_irq_stat[`CSPM_IRQ_RETRY] || retry;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pm_reg <= `CSPM_PM_RST; // [R4] [R5]
      tim_reg <= `CSPM_TIM_RST; // [R17]
      irq_mask <= '0;
      irq_stat <= '0;
      evt_flag <= 1'b0; // [R7]
    end else begin
      pm_reg <= next_pm_reg;
      tim_reg <= next_tim_reg;
      irq_mask <= next_irq_mask;
      irq_stat <= next_irq_stat;
      evt_flag <= next_evt_flag;
    end
  end

  assign mgmt_en = pm_reg[`CSPM_PM_MGMT];
  assign port_en = pm_reg[`CSPM_PM_PORT];
  assign spi_en = pm_reg[`CSPM_PM_SPI];
  assign lim = cspm_pkg::cspm_limit_t'(pm_reg[`CSPM_PM_LIM_LSB +: 2]);
  // The current code passes straight to the analog source; 001b is weakest, 000b strongest.
  assign charge_current_select = tim_reg[`CSPM_TIM_IA_LSB +: 3]; // [R18]
  assign ramp_control = tim_reg[`CSPM_TIM_RP_LSB +: 2];
  assign lowpass_corner_select = tim_reg[`CSPM_TIM_LP_LSB +: 3];
  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------
  // Conversion sequencer
  // ----------------------------------------
  // A slow-clock wake with monitoring on cannot stay stopped, so it starts a conversion.
  assign wake_start = wake_event && sysclk_below_wake_min && (mgmt_en || port_en || spi_en); // [R8]
  assign start_req = start_wr || wake_start;
  assign conv_start = (state == cspm_pkg::cspm_idle) && start_req;
  assign conv_busy = (state != cspm_pkg::cspm_idle);
  assign charge_enable = (state == cspm_pkg::cspm_charge);

  always_comb begin
    next_state = state;
    next_bit_idx = bit_idx;
    next_chg_cnt = chg_cnt;
    next_done = 1'b0;
    dis_start = 1'b0;
    unique case (state)
      cspm_pkg::cspm_idle: if (start_req) begin
        next_state = cspm_pkg::cspm_disch;
        next_bit_idx = '0;
        dis_start = 1'b1; // [R11]
      end
      cspm_pkg::cspm_disch: if (retry) begin
        dis_start = 1'b1; // [R1]
      end else if (dis_done) begin
        next_state = cspm_pkg::cspm_charge;
        next_chg_cnt = '0;
      end
      cspm_pkg::cspm_charge: if (retry) begin
        // Only the disturbed bit is redone; earlier bits stand.
        next_state = cspm_pkg::cspm_disch; // [R1]
        dis_start = 1'b1;
      end else if (chg_cnt == CHG_LAST) begin
        if (bit_idx == BIT_LAST) begin
          next_state = cspm_pkg::cspm_idle; // [R6]
          next_done = 1'b1;
        end else begin
          next_state = cspm_pkg::cspm_disch;
          next_bit_idx = bit_idx + 1'b1;
          dis_start = 1'b1; // [R11]
        end
      end else begin
        next_chg_cnt = chg_cnt + 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= cspm_pkg::cspm_idle;
      bit_idx <= '0;
      chg_cnt <= '0;
      conv_done <= 1'b0;
    end else begin
      state <= next_state;
      bit_idx <= next_bit_idx;
      chg_cnt <= next_chg_cnt;
      conv_done <= next_done;
    end
  end

  cspm_discharge #(.CNT_W(CNT_W)) u_discharge (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(dis_start),
    .primary_discharge_time(tim_reg[`CSPM_TIM_DT_LSB +: 3]), // [R13]
    .secondary_discharge_time(tim_reg[`CSPM_TIM_DR_LSB +: 2]), // [R13]
    .low_sw(discharge_low_sw),
    .high_sw(discharge_high_sw),
    .done(dis_done)
  );

  cspm_retry_gate u_retry (
    .clk(clk),
    .sys_rst(sys_rst),
    .conv_start(conv_start),
    .active(conv_busy),
    .mgmt_bus_switch(mgmt_bus_switch),
    .port_write_strobe(port_write_strobe),
    .serial_periph_switch(serial_periph_switch),
    .mgmt_bus_monitor_enable(mgmt_en),
    .port_write_monitor_enable(port_en),
    .serial_periph_monitor_enable(spi_en),
    .retry_limit_select(lim),
    .retry(retry),
    .retry_count(retry_count)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic first_cyc;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) first_cyc <= 1'b1;
    else first_cyc <= 1'b0;
  end

  default clocking dcb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_primary_end;
    discharge_low_sw ##1 !discharge_low_sw;
  endsequence
  sequence s_secondary_run;
    discharge_high_sw && !charge_enable;
  endsequence

  retry_flag_a: assert property (retry |=> evt_flag) // [R7]
    else $error("retry did not set the event flag");
  flag_hold_a: assert property (evt_flag && !evt_clr |=> evt_flag) // [R7]
    else $error("event flag dropped without a clear");
  spi_reset_a: assert property (first_cyc |-> !spi_en) // [R4]
    else $error("serial monitor enable not zero after reset");
  wake_start_a: assert property (!conv_busy && wake_start |=> conv_busy ##1 discharge_low_sw) // [R8]
    else $error("slow-clock wake did not start a conversion");
  stage_order_a: assert property (s_primary_end |-> s_secondary_run or discharge_low_sw) // [R12]
    else $error("primary stage not followed by secondary stage");
  charge_after_a: assert property ($rose(charge_enable) |-> $past(discharge_high_sw, 2)) // [R11]
    else $error("charging began without a two-stage discharge");
  retry_redo_a: assert property (charge_enable && retry |=> !charge_enable ##1 discharge_low_sw) // [R1]
    else $error("retry during charge did not redo the bit");
  stage_excl_a: assert property (!(discharge_low_sw && discharge_high_sw) && !(charge_enable && discharge_low_sw)) // [R12]
    else $error("discharge switches overlap");
endmodule : cspm_top

// ### verif/cspm_sensor_model.sv
`timescale 1ns/100ps
module cspm_sensor_model (
  input wire logic clk,
  input wire logic low_sw,
  input wire logic high_sw,
  input wire logic charge_enable,
  output logic discharged
);
  // ----------------------------------------
  // Electrode charge state
  // ----------------------------------------
  // The soft stage only counts once the hard stage has drained the bulk charge.
  logic hard_done = 1'h0;
  initial discharged = 1'h0;
  always @(posedge clk) begin
    hard_done <= low_sw || (hard_done && !charge_enable);
    discharged <= !low_sw && !charge_enable && (discharged || (hard_done && high_sw));
  end
endmodule : cspm_sensor_model

// ### verif/tb_top.sv
`timescale 1ns/100ps
`include "cspm_defines.svh"
module tb_top;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic mgmt_bus_switch = 1'h0, port_write_strobe = 1'h0, serial_periph_switch = 1'h0;
  logic wake_event = 1'h0, sysclk_below_wake_min = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic discharge_low_sw, discharge_high_sw, charge_enable, conv_busy, conv_done, discharged;
  logic [2:0] charge_current_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  cspm_top u_dut (.*, .ramp_control(), .lowpass_corner_select());
  cspm_sensor_model u_sensor (.clk(clk), .low_sw(discharge_low_sw), .high_sw(discharge_high_sw),
    .charge_enable(charge_enable), .discharged(discharged));
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // Every wait is bounded; a stuck level wait ends the run, and a stuck bus handshake is counted as a mismatch.
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    for (n = 0; n < lim && s !== v; n++) @(posedge clk);
    if (n >= lim) begin
      n_mismatch++;
      $display("mismatch wait_limit expected %0d seen %0d", lim, n);
      summarize();
    end
  endtask : wait_lvl
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      n++;
    end while (n < 100 && s_axi_bvalid !== 1'h1);
    chk("write_done", 1, s_axi_bvalid);
    chk("write_resp", 0, s_axi_bresp);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      n++;
    end while (n < 100 && s_axi_rvalid !== 1'h1);
    chk("read_done", 1, s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h04, d, r);
    chk("monitor_reset", 32'h0000_0000, d);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, d, r);
    chk("monitor_writable", `CSPM_PM_MASK, d);
    wr(8'h04, 32'h0000_0000);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, d, r);
    chk("timing_writable", `CSPM_TIM_MASK, d);
    chk("current_select", 3'h7, charge_current_select);
    rd(8'h18, d, r);
    chk("unmapped_resp", 2'h2, r);
    $display("test registers done");
  endtask : t_regs
  task automatic t_disch(input logic [2:0] dt, input logic [1:0] dr);
    int n;
    wr(8'h08, (32'(dr) << 4) | 32'(dt));
    wr(8'h00, 32'h0000_0001);
    wait_lvl(discharge_low_sw, 1'h1, 100, n);
    wait_lvl(discharge_low_sw, 1'h0, 2000, n);
    chk("primary_len", (dt + 1) * `CSPM_PRI_STEP_CYC, n);
    chk("high_after_low", 1, discharge_high_sw);
    wait_lvl(discharge_high_sw, 1'h0, 2000, n);
    chk("secondary_len", (dr + 1) * `CSPM_SEC_STEP_CYC, n);
    chk("electrode_discharged", 1, discharged);
    wait_lvl(conv_busy, 1'h0, 9000, n);
    chk("conv_done", 1, conv_done);
    $display("test discharge %0d %0d done", dt, dr);
  endtask : t_disch
  task automatic t_retry(input logic [31:0] pm, input logic [2:0] sel, input int pulses, input int exp);
    int n;
    logic [31:0] d;
    logic [1:0] r;
    wr(8'h04, pm);
    wr(8'h10, 32'h0000_0002);
    wr(8'h00, 32'h0000_0001);
    wait_lvl(charge_enable, 1'h1, 300, n);
    repeat (pulses) begin
      {serial_periph_switch, port_write_strobe, mgmt_bus_switch} <= sel;
      @(posedge clk);
      {serial_periph_switch, port_write_strobe, mgmt_bus_switch} <= 3'h0;
      repeat (3) @(posedge clk);
    end
    rd(8'h14, d, r);
    chk("retry_count", exp, d[7:0]);
    rd(8'h00, d, r);
    chk("event_flag", exp != 0, d[2]);
    chk("irq_on_retry", exp != 0, irq);
    rd(8'h0C, d, r);
    chk("retry_status", exp != 0, d[1]);
    @(posedge clk);
    chk("irq_after_read", 0, irq);
    wr(8'h00, 32'h0000_0004);
    rd(8'h00, d, r);
    chk("event_cleared", 0, d[2]);
    wait_lvl(conv_busy, 1'h0, 9000, n);
    $display("test retry %h done", pm);
  endtask : t_retry
  task automatic t_wake;
    int n;
    wr(8'h04, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      sysclk_below_wake_min <= i[0];
      wake_event <= 1'h1;
      @(posedge clk);
      wake_event <= 1'h0;
      repeat (3) @(posedge clk);
      chk("wake_start", i, conv_busy);
    end
    wait_lvl(conv_busy, 1'h0, 9000, n);
    sysclk_below_wake_min <= 1'h0;
    $display("test wake done");
  endtask : t_wake
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    t_regs();
    t_disch(3'h0, 2'h0);
    t_disch(3'h7, 2'h0);
    t_disch(3'h7, 2'h3);
    t_disch(3'h2, 2'h1);
    t_retry(32'h0000_0003, 3'h4, 3, 0);
    t_retry(32'h0000_0012, 3'h2, 4, 2);
    t_retry(32'h0000_0001, 3'h1, 5, 5);
    t_retry(32'h0000_0024, 3'h4, 6, 4);
    t_wake();
    summarize();
  end
endmodule : tb_top
